/* verilog/spi_port_map.svh */
`ifndef SPI_PORT_MAP_SVH
`define SPI_PORT_MAP_SVH

// Bits in one serial frame.
`define FRAME_BITS 16
// Width of a register byte address.
`define ADDR_BITS 7
// Position of the write flag in the command word.
`define CMD_WRITE_BIT 15
// Position of the address field in the command word.
`define CMD_ADDR_LSB 8
// Reset value of the output shift register.
`define TX_RESET 16'h0000
// Least chip-select high time between frames, in nanoseconds.
`define STALL_NORMAL_NS 9000
`define STALL_LOWPWR_NS 12000
// Core clock period in nanoseconds.
`define CORE_PERIOD_NS 40

`endif

/* verilog/spi_port_pkg.sv */
package spi_port_pkg;
  // Kind of frame that just completed.
  typedef enum logic [1:0] {
    FRAME_NONE,
    FRAME_READ,
    FRAME_WRITE
  } frame_kind_t;
endpackage : spi_port_pkg

/* verilog/gyro_spi_slave_port.sv */
`timescale 1ns/1ps
`include "spi_port_map.svh"
module gyro_spi_slave_port #(
  parameter int FRAME_BITS = `FRAME_BITS
) (
  // Clock, reset and enable.
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_en,
  // Serial pins from the master.
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  // Serial output pin and its active-low output enable.
  output logic dout,
  output logic dout_oe_n,
  // Register side: read request and returned word.
  output logic [`ADDR_BITS-1:0] rd_addr,
  output logic rd_req,
  input wire logic [15:0] rd_data,
  // Register side: one-byte write.
  output logic [`ADDR_BITS-1:0] wr_addr,
  output logic [7:0] wr_data,
  output logic wr_strobe,
  // Master breaking the least stall time.
  input wire logic low_power_mode,
  output logic stall_violation
);
  import spi_port_pkg::*;

  // ---------------------------------------------------------------
  // Constants
  // ---------------------------------------------------------------
  // Least stall counts, rounded up to whole core cycles.
  localparam int STALL_N =
    (`STALL_NORMAL_NS + `CORE_PERIOD_NS - 1) / `CORE_PERIOD_NS;
  localparam int STALL_L =
    (`STALL_LOWPWR_NS + `CORE_PERIOD_NS - 1) / `CORE_PERIOD_NS;

  // Refuse a frame length the counter and shifters cannot serve.
  if (FRAME_BITS != 16) begin : g_bad_len
    $error("Frame length must be sixteen bits.");
  end

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  // All state of the port in one record.
  typedef struct packed {
    logic [1:0] sclk_s;    // Serial clock synchroniser.
    logic [1:0] cs_s;      // Select synchroniser.
    logic [1:0] din_s;     // Input data synchroniser.
    logic sclk_d;          // Previous synchronised clock.
    logic cs_d;            // Previous synchronised select.
    logic [4:0] bit_cnt;   // Bits captured in this frame.
    logic [15:0] rx;       // Input shift register.
    logic [15:0] tx;       // Output shift register.
    logic [15:0] pend;     // Word to send in next frame.
    logic [`ADDR_BITS-1:0] rd_addr;
    logic rd_req;
    logic [`ADDR_BITS-1:0] wr_addr;
    logic [7:0] wr_data;
    logic wr_strobe;
    logic rd_wait;         // Read data due next cycle.
    logic [13:0] idle_cnt; // Core cycles with select high.
    logic viol;
    logic dout;
    logic oe_n;
  } state_t;

  state_t s;
  state_t next_s;
  frame_kind_t kind;

  // Classify a finished command word.
  function automatic frame_kind_t classify(input logic [15:0] w);
    return w[`CMD_WRITE_BIT] ? FRAME_WRITE : FRAME_READ;
  endfunction : classify

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  // Synchronise pins, find clock edges, shift and decode frames.
  always_comb begin
    logic rise;
    logic fall;
    logic sel;
    logic [15:0] word;
    rise = 1'b0;
    fall = 1'b0;
    sel = 1'b0;
    word = 16'h0000;
    next_s = s;
    kind = FRAME_NONE;
    next_s.sclk_s = {s.sclk_s[0], sclk};
    next_s.cs_s = {s.cs_s[0], cs_n};
    next_s.din_s = {s.din_s[0], din};
    next_s.sclk_d = s.sclk_s[1];
    next_s.cs_d = s.cs_s[1];
    next_s.rd_req = 1'b0;
    next_s.wr_strobe = 1'b0;
    next_s.rd_wait = s.rd_req;
    sel = !s.cs_s[1];
    rise = sel && s.sclk_s[1] && !s.sclk_d;
    fall = sel && !s.sclk_s[1] && s.sclk_d;
    // Returned word is held for the next frame.
    if (s.rd_wait) begin
      next_s.pend = rd_data;
    end
    if (!sel) begin
      // Deselected: discard partial frame, float the output.
      next_s.bit_cnt = 5'd0;
      next_s.oe_n = 1'b1;
      if (s.idle_cnt != 14'h3fff) begin
        next_s.idle_cnt = s.idle_cnt + 14'd1;
      end
    end else begin
      if (s.cs_d) begin
        // Select just fell: present MSB before any clock edge.
        next_s.tx = s.pend;
        next_s.dout = s.pend[15];
        next_s.oe_n = 1'b0;
        if (int'(s.idle_cnt) <
            (low_power_mode ? STALL_L : STALL_N)) begin
          next_s.viol = 1'b1;
        end else begin
          next_s.viol = 1'b0;
        end
        next_s.idle_cnt = 14'd0;
      end
      // The first fall of a frame keeps the MSB that select put out, so
      // the master still finds it at the first rise; later falls shift.
      if (fall && !s.cs_d && s.bit_cnt != 5'd0) begin
        next_s.tx = {s.tx[14:0], 1'b0};
        next_s.dout = s.tx[14];
      end
      if (rise) begin
        word = {s.rx[14:0], s.din_s[1]};
        next_s.rx = word;
        if (s.bit_cnt == 5'(FRAME_BITS - 1)) begin
          next_s.bit_cnt = 5'd0;
          kind = classify(word);
          next_s.rd_addr = word[`CMD_ADDR_LSB +: `ADDR_BITS];
          if (kind == FRAME_WRITE) begin
            next_s.wr_addr = word[`CMD_ADDR_LSB +: `ADDR_BITS];
            next_s.wr_data = word[7:0];
            next_s.wr_strobe = 1'b1;
          end else begin
            next_s.rd_req = 1'b1;
          end
        end else begin
          next_s.bit_cnt = s.bit_cnt + 5'd1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  // Synchronous reset; the enable freezes every flip-flop.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      s <= '0;
      s.sclk_s <= 2'b11;
      s.cs_s <= 2'b11;
      s.sclk_d <= 1'b1;
      s.cs_d <= 1'b1;
      s.tx <= `TX_RESET;
      s.pend <= `TX_RESET;
      s.oe_n <= 1'b1;
      s.idle_cnt <= 14'h3fff;
    end else if (clk_en) begin
      s <= next_s;
    end
  end

  // Outputs straight from the record.
  assign dout = s.dout;
  assign dout_oe_n = s.oe_n;
  assign rd_addr = s.rd_addr;
  assign rd_req = s.rd_req;
  assign wr_addr = s.wr_addr;
  assign wr_data = s.wr_data;
  assign wr_strobe = s.wr_strobe;
  assign stall_violation = s.viol;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset || !clk_en);

  // Synchronised select high means the output floats next cycle.
  a_output_float: assert property (
    s.cs_s[1] |=> dout_oe_n) else $error("Output driven while deselected.");

  // The first clock fall of a frame leaves the MSB in place.
  a_msb_hold: assert property (
    (!s.cs_s[1] && !s.cs_d && !s.sclk_s[1] && s.sclk_d &&
     s.bit_cnt == 5'd0) |=> $stable(dout))
    else $error("MSB lost at the first clock fall.");

  // Falling select loads the MSB.
  a_msb_first: assert property (
    (!s.cs_s[1] && s.cs_d) |=> (dout == $past(s.pend[15]) && !dout_oe_n))
    else $error("MSB not driven at select fall.");

  // Output changes only on a clock fall or select fall.
  a_dout_edge: assert property (
    (!s.cs_s[1] && !s.cs_d && !(!s.sclk_s[1] && s.sclk_d))
    |=> $stable(dout)) else $error("Output changed off a falling edge.");

  // Deselect clears the counter.
  a_cnt_clear: assert property (
    s.cs_s[1] |=> s.bit_cnt == 5'd0) else $error("Counter kept.");

  // Write strobes only follow a rising edge on the sixteenth bit.
  a_wr_cause: assert property (
    wr_strobe |-> $past(s.bit_cnt) == 5'd15)
    else $error("Write without full frame.");

  // Read requests are single pulses.
  a_rd_pulse: assert property (
    rd_req |=> !rd_req) else $error("Read request held.");

  // Input shifts only on rising clock edges while selected.
  a_rx_edge: assert property (
    !(!s.cs_s[1] && s.sclk_s[1] && !s.sclk_d) |=> $stable(s.rx))
    else $error("Input shifted off a rising edge.");

  // No activity while deselected.
  a_ignore_idle: assert property (
    s.cs_s[1] |=> (!wr_strobe && !rd_req))
    else $error("Frame acted while deselected.");

  // Read and write never pair.
  a_one_kind: assert property (
    !(wr_strobe && rd_req)) else $error("Both strobes high.");

  // Read request, then the cycle in which the returned word is taken.
  sequence s_rd_taken;
    rd_req ##1 1'b1;
  endsequence

  // Word returned for a read is queued for next frame.
  a_rd_word: assert property (
    s_rd_taken |=> s.pend == $past(rd_data))
    else $error("Read word not captured.");
endmodule : gyro_spi_slave_port

/* dv/spi_master_model.sv */
`timescale 1ns/1ps
// ----------
// Master model
// ----------
module spi_master_model #(
  parameter int HALF_NS = 160
) (
  // Serial pins toward the device.
  output logic sclk,
  output logic cs_n,
  output logic din,
  // Reply from the device.
  input wire logic dout
);
  // Clock and select idle high.
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    din = 1'b0;
  end
  // Sends nbits MSB first and gathers the reply on rising edges.
  task automatic xfer(input logic [15:0] tx, input int nbits,
                      output logic [15:0] rx);
    cs_n = 1'b0;
    #(HALF_NS);
    for (int i = 0; i < nbits; i++) begin
      sclk = 1'b0;
      din = tx[15-i];
      #(HALF_NS);
      sclk = 1'b1;
      rx = {rx[14:0], dout};
      #(HALF_NS);
    end
    cs_n = 1'b1;
    // Released input flips so a stale level is never trusted.
    din = ~din;
  endtask : xfer
  // Toggles the clock and data with select high; the slave must ignore it.
  task automatic idle_clocks(input int n);
    for (int i = 0; i < n; i++) begin
      sclk = 1'b0;
      din = ~din;
      #(HALF_NS);
      sclk = 1'b1;
      #(HALF_NS);
    end
  endtask : idle_clocks
endmodule : spi_master_model

/* dv/testbench.sv */
`timescale 1ns/1ps
// ----------
// Bench top
// ----------
module testbench;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic clk_en = 1'b1;
  logic low_power_mode = 1'b0;
  logic [15:0] rd_data = 16'h0000;
  logic sclk, cs_n, din, dout, dout_oe_n, rd_req, wr_strobe, stall_violation;
  logic [6:0] rd_addr, wr_addr, a;
  logic [7:0] wr_data, d;
  logic [15:0] rx;
  int err_count = 0;
  int check_count = 0;
  int wr_count = 0;
  int rd_count = 0;
  int last_gap = 0;
  int n, r, p, g;
  // Line seen by the master; released, it shows the stale level inverted.
  wire logic miso = dout_oe_n ? ~dout : dout;
  // Core clock of 40 ns.
  always #20 core_clk = ~core_clk;
  gyro_spi_slave_port dut (.core_clk(core_clk), .reset(reset),
    .clk_en(clk_en), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout),
    .dout_oe_n(dout_oe_n), .rd_addr(rd_addr), .rd_req(rd_req),
    .rd_data(rd_data), .wr_addr(wr_addr), .wr_data(wr_data),
    .wr_strobe(wr_strobe), .low_power_mode(low_power_mode),
    .stall_violation(stall_violation));
  spi_master_model m (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(miso));
  // Register contents: one word per pair of byte addresses.
  function automatic logic [15:0] word_of(logic [6:0] x);
    return {x[6:1], 2'b10, 8'h3c ^ {2'b00, x[6:1]}};
  endfunction : word_of
  // Least stall the master owes in each sampling mode, in ns.
  function automatic int stall_min(logic lp);
    return lp ? 12000 : 9000;
  endfunction : stall_min
  // Register side answers at the falling edge.
  always @(negedge core_clk) rd_data <= word_of(rd_addr);
  // Counts strobes at the falling edge, once they have settled.
  always @(negedge core_clk) begin
    if (wr_strobe === 1'b1) wr_count <= wr_count + 1;
    if (rd_req === 1'b1) rd_count <= rd_count + 1;
  end
  // Compares one value.
  task automatic check(logic [15:0] seen, logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Prints counts and verdict.
  task automatic test_done;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done
  // One frame, then a stall whose last frz ns have the core frozen; the
  // output must stand released at its end.
  task automatic frame(logic [15:0] tx, int nbits, int gap, int frz);
    m.xfer(tx, nbits, rx);
    #(gap - frz);
    if (frz > 0) begin
      clk_en = 1'b0;
      #(frz);
      clk_en = 1'b1;
    end
    check(dout_oe_n, 1'b1);
    last_gap = gap - frz;
  endtask : frame
  // Watchdog cuts a hang short.
  initial begin
    #3ms;
    err_count++;
    test_done();
  end
  // Main sequence.
  initial begin
    void'($urandom(32'hf12d));
    repeat (2) @(posedge core_clk);
    @(negedge core_clk) reset = 1'b0;
    // Cut frame and clocking while deselected.
    n = wr_count;
    r = rd_count;
    frame(16'hffff, 8, 9600, 0);
    check(wr_count, n);
    check(rd_count, r);
    m.idle_clocks(16);
    check(wr_count, n);
    check(rd_count, r);
    $display("discard test done");
    // Random writes.
    for (int i = 0; i < 6; i++) begin
      a = $urandom;
      d = $urandom;
      n = wr_count;
      frame({1'b1, a, d}, 16, 9600, 0);
      check(wr_count, n + 1);
      check(wr_addr, a);
      check(wr_data, d);
    end
    $display("write test done");
    // Reads through both byte addresses.
    for (int i = 0; i < 6; i++) begin
      a = $urandom;
      a[0] = i[0];
      r = rd_count;
      frame({1'b0, a, 8'h00}, 16, 9600, 0);
      check(rd_addr, a);
      check(rd_count, r + 1);
      frame(16'h0000, 16, 9600, 0);
      check(rx, word_of(a));
    end
    $display("read test done");
    // Stalls in both sampling modes, on either side of each limit.
    for (int lp = 0; lp < 2; lp++) begin
      low_power_mode = lp[0];
      for (int j = 0; j < 5; j++) begin
        case (j)
          0: g = 4000;
          1: g = stall_min(lp[0]) - 40;
          2: g = stall_min(lp[0]);
          default: g = 40 * (100 + $urandom_range(300));
        endcase
        p = last_gap;
        frame(16'h0000, 16, g, 0);
        check(stall_violation, p < stall_min(lp[0]));
      end
    end
    $display("stall test done");
    // Frozen cycles do not count toward the stall.
    low_power_mode = 1'b0;
    frame(16'h0000, 16, 9600, 1600);
    p = last_gap;
    frame(16'h0000, 16, 4000, 0);
    check(stall_violation, p < stall_min(1'b0));
    $display("freeze test done");
    // Reset in mid-run: status and queued word clear, a frame may follow.
    reset = 1'b1;
    repeat (2) @(negedge core_clk);
    reset = 1'b0;
    check(stall_violation, 1'b0);
    check(dout_oe_n, 1'b1);
    frame(16'h0000, 16, 9600, 0);
    check(stall_violation, 1'b0);
    check(rx, 16'h0000);
    $display("reset test done");
    test_done();
  end
endmodule : testbench
